/* File: mrtd_defs.vh */
// Behaviour
// - memory type comes from field bits 2:0
// - extended: bits 7:5 reserved, 4:3 route bits
// - extended encoding only for fixed-range entries
// - standard values unless extended explicitly enabled
// - type zero: uncacheable, no combine, no speculation
// - type one: write-combining, uncached, speculative reads
// - type four: write-through, read allocates only
// - type five: write-protect, write hit invalidates
// - type six: write-back, write miss allocates modified
// - range mechanism disabled forces uncacheable
// - most restrictive of combined types wins
// - eight byte-wide fields per 64-bit fixed entry
`ifndef MRTD_DEFS_VH
`define MRTD_DEFS_VH
`define MRTD_TYPE_MSB 2
`define MRTD_RSV_STD_MSB 7
`define MRTD_RSV_STD_LSB 3
`define MRTD_RSV_EXT_MSB 7
`define MRTD_RSV_EXT_LSB 5
`define MRTD_RD_ROUTE_BIT 4
`define MRTD_WR_ROUTE_BIT 3
`define MRTD_FIELDS 8
`define MRTD_FIELD_W 8
`define MRTD_SEL_W 3
`define MRTD_TYPE_UNCACHED 3'h0
`define MRTD_TYPE_COMBINE 3'h1
`define MRTD_TYPE_THROUGH 3'h4
`define MRTD_TYPE_PROTECT 3'h5
`define MRTD_TYPE_BACK 3'h6
`define MRTD_RANK_UNCACHED 3'h0
`define MRTD_RANK_COMBINE 3'h1
`define MRTD_RANK_PROTECT 3'h2
`define MRTD_RANK_THROUGH 3'h3
`define MRTD_RANK_BACK 3'h4
`define MRTD_RESET_FIELD 8'h00
`endif

/* File: mrtd_field_select.v */
`timescale 1ns/1ps
`default_nettype none
`include "mrtd_defs.vh"
// picks one of eight byte-wide type fields out of a 64-bit entry
module mrtd_field_select (
  input wire [63:0] entry,
  input wire [2:0] sel,
  output wire [7:0] field
);
  wire [7:0] slice [0:7];
  genvar i;
  // byte-aligned fields, field i at bits 8i+7:8i
  generate
    for (i = 0; i < `MRTD_FIELDS; i = i + 1) begin : g_slice
      assign slice[i] = entry[i*8 +: 8];
    end
  endgenerate
  assign field = slice[sel];
endmodule // mrtd_field_select
`default_nettype wire

/* File: mrtd_type_decode.v */
`timescale 1ns/1ps
`default_nettype none
`include "mrtd_defs.vh"
// decodes one type field into a restriction rank plus route and error flags
module mrtd_type_decode (
  input wire [7:0] field,
  input wire ext_allowed,
  output reg [2:0] rank,
  output reg invalid,
  output reg rsv_err,
  output reg rd_route,
  output reg wr_route
);
  // only the low three bits name the type, in both variants
  always @* begin
    rd_route = 1'b0;
    wr_route = 1'b0;
    invalid = 1'b0;
    case (field[`MRTD_TYPE_MSB:0])
      `MRTD_TYPE_UNCACHED: rank = `MRTD_RANK_UNCACHED;
      `MRTD_TYPE_COMBINE: rank = `MRTD_RANK_COMBINE;
      `MRTD_TYPE_THROUGH: rank = `MRTD_RANK_THROUGH;
      `MRTD_TYPE_PROTECT: rank = `MRTD_RANK_PROTECT;
      `MRTD_TYPE_BACK: rank = `MRTD_RANK_BACK;
      default: begin
        rank = `MRTD_RANK_UNCACHED;
        invalid = 1'b1;
      end
    endcase
    if (ext_allowed) begin
      // route bits live in 4:3 only when extended is in force
      rd_route = field[`MRTD_RD_ROUTE_BIT];
      wr_route = field[`MRTD_WR_ROUTE_BIT];
      rsv_err = |field[`MRTD_RSV_EXT_MSB:`MRTD_RSV_EXT_LSB];
    end else begin
      // software is expected to keep these clear; we just report it
      rsv_err = |field[`MRTD_RSV_STD_MSB:`MRTD_RSV_STD_LSB];
    end
  end
endmodule // mrtd_type_decode
`default_nettype wire

/* File: mrtd_decoder.v */
`timescale 1ns/1ps
`default_nettype none
`include "mrtd_defs.vh"
// memory range type decoder: turns range type fields plus the page-level
// type into the cache policy for one access. the decoded policy is registered
// along with lookup_valid, so the policy appears one cycle after lookup_valid
// together with policy_valid_reg, never later.
module mrtd_decoder (
  input wire clk,
  input wire rstn,
  input wire range_enable,
  input wire ext_type_enable,
  input wire global_cache_disable,
  input wire lookup_valid,
  input wire lookup_is_fixed,
  input wire [63:0] fixed_entry,
  input wire [2:0] fixed_field_sel,
  input wire [7:0] var_type_field,
  input wire [2:0] page_rank,
  output reg policy_valid_reg,
  output reg [2:0] policy_rank_reg,
  output reg bypass_cache_reg,
  output reg read_alloc_reg,
  output reg write_alloc_reg,
  output reg write_through_reg,
  output reg write_hit_invalidate_reg,
  output reg write_combine_ok_reg,
  output reg speculate_ok_reg,
  output reg read_memory_route_bit_reg,
  output reg write_memory_route_bit_reg,
  output reg type_invalid_reg,
  output reg reserved_err_reg
);
  wire [7:0] fixed_field;
  wire [7:0] sel_field;
  wire ext_allowed;
  wire [2:0] range_rank;
  wire dec_invalid;
  wire dec_rsv;
  wire dec_rd;
  wire dec_wr;
  reg [2:0] eff_rank;
  reg [2:0] rank_next;

  // most restrictive rank is the numerically smaller one
  function [2:0] mrtd_min_rank;
    input [2:0] a;
    input [2:0] b;
    begin
      mrtd_min_rank = (a < b) ? a : b;
    end
  endfunction

  mrtd_field_select u_sel (
    .entry(fixed_entry),
    .sel(fixed_field_sel),
    .field(fixed_field)
  );

  // variable entries always decode standard even if extended is on
  assign ext_allowed = ext_type_enable & lookup_is_fixed;
  assign sel_field = lookup_is_fixed ? fixed_field : var_type_field;

  mrtd_type_decode u_dec (
    .field(sel_field),
    .ext_allowed(ext_allowed),
    .rank(range_rank),
    .invalid(dec_invalid),
    .rsv_err(dec_rsv),
    .rd_route(dec_rd),
    .wr_route(dec_wr)
  );

  // disabled range mechanism wins regardless of the cache-disable bit;
  // a cache-disable request also forces the uncacheable rank
  always @* begin
    if (!range_enable || global_cache_disable) begin
      eff_rank = `MRTD_RANK_UNCACHED;
    end else begin
      eff_rank = range_rank;
    end
    rank_next = mrtd_min_rank(eff_rank, page_rank);
  end

  // next values of the output flops, one per output
  reg policy_valid_next;
  reg bypass_cache_next;
  reg read_alloc_next;
  reg write_alloc_next;
  reg write_through_next;
  reg write_hit_invalidate_next;
  reg write_combine_ok_next;
  reg speculate_ok_next;
  reg read_memory_route_bit_next;
  reg write_memory_route_bit_next;
  reg type_invalid_next;
  reg reserved_err_next;

  // valid rides the same flop stage as the policy, so the qualifier and
  // the policy it qualifies can never drift apart
  always @* begin
    policy_valid_next = lookup_valid;
  end

  // the policy depends on the final rank alone; spelling out every rank
  // keeps each cache control next to its type. ranks above write-back are
  // meaningless and fall to the default, which never caches
  always @* begin
    case (rank_next)
      `MRTD_RANK_UNCACHED: begin
        // no caching, no merging and no speculative access at all
        bypass_cache_next = 1'b1;
        read_alloc_next = 1'b0;
        write_alloc_next = 1'b0;
        write_through_next = 1'b0;
        write_hit_invalidate_next = 1'b0;
        write_combine_ok_next = 1'b0;
        speculate_ok_next = 1'b0;
      end
      `MRTD_RANK_COMBINE: begin
        // uncached, but writes may merge and reads may run ahead
        bypass_cache_next = 1'b1;
        read_alloc_next = 1'b0;
        write_alloc_next = 1'b0;
        write_through_next = 1'b0;
        write_hit_invalidate_next = 1'b0;
        write_combine_ok_next = 1'b1;
        speculate_ok_next = 1'b1;
      end
      `MRTD_RANK_PROTECT: begin
        // reads allocate; every write reaches memory and kills a hit line
        bypass_cache_next = 1'b0;
        read_alloc_next = 1'b1;
        write_alloc_next = 1'b0;
        write_through_next = 1'b1;
        write_hit_invalidate_next = 1'b1;
        write_combine_ok_next = 1'b0;
        speculate_ok_next = 1'b1;
      end
      `MRTD_RANK_THROUGH: begin
        // reads allocate, write misses do not, write hits update both
        bypass_cache_next = 1'b0;
        read_alloc_next = 1'b1;
        write_alloc_next = 1'b0;
        write_through_next = 1'b1;
        write_hit_invalidate_next = 1'b0;
        write_combine_ok_next = 1'b0;
        speculate_ok_next = 1'b1;
      end
      `MRTD_RANK_BACK: begin
        // both misses allocate; a write miss lands in the modified state
        bypass_cache_next = 1'b0;
        read_alloc_next = 1'b1;
        write_alloc_next = 1'b1;
        write_through_next = 1'b0;
        write_hit_invalidate_next = 1'b0;
        write_combine_ok_next = 1'b0;
        speculate_ok_next = 1'b1;
      end
      default: begin
        // no page rank gets here, since rank_next is at most eff_rank (write-back or below); act uncached anyway
        bypass_cache_next = 1'b1;
        read_alloc_next = 1'b0;
        write_alloc_next = 1'b0;
        write_through_next = 1'b0;
        write_hit_invalidate_next = 1'b0;
        write_combine_ok_next = 1'b0;
        speculate_ok_next = 1'b0;
      end
    endcase
  end

  // route and error flags mean nothing while the range mechanism is off,
  // so they are masked there instead of confusing the consumer
  always @* begin
    read_memory_route_bit_next = dec_rd & range_enable;
    write_memory_route_bit_next = dec_wr & range_enable;
    type_invalid_next = dec_invalid & range_enable;
    reserved_err_next = dec_rsv & range_enable;
  end

  // qualifier and rank flops; reset shows an idle, uncacheable policy
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      policy_valid_reg <= 1'b0;
      policy_rank_reg <= `MRTD_RANK_UNCACHED;
    end else begin
      policy_valid_reg <= policy_valid_next;
      policy_rank_reg <= rank_next;
    end
  end

  // cache control flops; the reset value bypasses the cache so that nothing
  // allocates during reset; after it the flops load the decoded policy every cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bypass_cache_reg <= 1'b1;
      read_alloc_reg <= 1'b0;
      write_alloc_reg <= 1'b0;
      write_through_reg <= 1'b0;
      write_hit_invalidate_reg <= 1'b0;
      write_combine_ok_reg <= 1'b0;
      speculate_ok_reg <= 1'b0;
    end else begin
      bypass_cache_reg <= bypass_cache_next;
      read_alloc_reg <= read_alloc_next;
      write_alloc_reg <= write_alloc_next;
      write_through_reg <= write_through_next;
      write_hit_invalidate_reg <= write_hit_invalidate_next;
      write_combine_ok_reg <= write_combine_ok_next;
      speculate_ok_reg <= speculate_ok_next;
    end
  end

  // route and error flag flops
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_memory_route_bit_reg <= 1'b0;
      write_memory_route_bit_reg <= 1'b0;
      type_invalid_reg <= 1'b0;
      reserved_err_reg <= 1'b0;
    end else begin
      read_memory_route_bit_reg <= read_memory_route_bit_next;
      write_memory_route_bit_reg <= write_memory_route_bit_next;
      type_invalid_reg <= type_invalid_next;
      reserved_err_reg <= reserved_err_next;
    end
  end
endmodule // mrtd_decoder
`default_nettype wire

/* File: mrtd_cache_model.sv */
`timescale 1ns/1ps
`default_nettype none
// cache side: keeps the last policy handed over, ignores idle cycles
module mrtd_cache_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pv,
  input wire logic [13:0] pol,
  output logic [13:0] held_reg
);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) held_reg <= 14'h0000;
    else if (pv) held_reg <= pol;
  end
endmodule // mrtd_cache_model
`default_nettype wire

/* File: mrtd_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the decoder's pins; checks from inputs are one register stage deep, policy and invalid checks look at one cycle
module mrtd_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic range_enable,
  input wire logic ext_type_enable,
  input wire logic global_cache_disable,
  input wire logic lookup_valid,
  input wire logic lookup_is_fixed,
  input wire logic [2:0] page_rank,
  input wire logic policy_valid_reg,
  input wire logic [2:0] policy_rank_reg,
  input wire logic bypass_cache_reg,
  input wire logic read_alloc_reg,
  input wire logic write_alloc_reg,
  input wire logic write_through_reg,
  input wire logic write_hit_invalidate_reg,
  input wire logic write_combine_ok_reg,
  input wire logic speculate_ok_reg,
  input wire logic read_memory_route_bit_reg,
  input wire logic write_memory_route_bit_reg,
  input wire logic type_invalid_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_LAT: assert property (lookup_valid |=> policy_valid_reg)
    else $error("policy valid late");
  AST_IDLE: assert property (
    !lookup_valid |=> !policy_valid_reg)
    else $error("policy valid without lookup");
  AST_OFF: assert property (
    !range_enable |=> policy_rank_reg == 3'h0)
    else $error("range off but cacheable");
  AST_CD: assert property (
    global_cache_disable |=> policy_rank_reg == 3'h0)
    else $error("cache disable but cacheable");
  AST_NOCACHE: assert property (
    policy_rank_reg == 3'h0 |->
    bypass_cache_reg && !speculate_ok_reg && !write_combine_ok_reg)
    else $error("uncacheable policy wrong");
  AST_COMBINE: assert property (
    policy_rank_reg == 3'h1 |-> bypass_cache_reg && write_combine_ok_reg)
    else $error("combining policy wrong");
  AST_THROUGH: assert property (
    policy_rank_reg == 3'h3 |->
    write_through_reg && read_alloc_reg && !write_alloc_reg)
    else $error("write-through policy wrong");
  AST_PROTECT: assert property (
    policy_rank_reg == 3'h2 |->
    write_hit_invalidate_reg && read_alloc_reg && !write_alloc_reg)
    else $error("write-protect policy wrong");
  AST_BACK: assert property (
    policy_rank_reg == 3'h4 |-> write_alloc_reg && !bypass_cache_reg)
    else $error("write-back policy wrong");
  AST_MIN: assert property (
    policy_rank_reg <= $past(page_rank))
    else $error("rank above page");
  AST_RTE: assert property (
    read_memory_route_bit_reg |->
    $past(lookup_is_fixed) && $past(ext_type_enable))
    else $error("read route outside fixed extended");
  AST_WRTE: assert property (
    write_memory_route_bit_reg |->
    $past(lookup_is_fixed) && $past(ext_type_enable))
    else $error("write route outside fixed extended");
  AST_INV: assert property (
    type_invalid_reg |-> policy_rank_reg == 3'h0)
    else $error("invalid type but cacheable");
  cover property (policy_rank_reg == 3'h4);
  cover property (type_invalid_reg);
  cover property (read_memory_route_bit_reg);
endmodule // mrtd_chk
bind mrtd_decoder mrtd_chk u_chk (
  .clk(clk),
  .rstn(rstn),
  .range_enable(range_enable),
  .ext_type_enable(ext_type_enable),
  .global_cache_disable(global_cache_disable),
  .lookup_valid(lookup_valid),
  .lookup_is_fixed(lookup_is_fixed),
  .page_rank(page_rank),
  .policy_valid_reg(policy_valid_reg),
  .policy_rank_reg(policy_rank_reg),
  .bypass_cache_reg(bypass_cache_reg),
  .read_alloc_reg(read_alloc_reg),
  .write_alloc_reg(write_alloc_reg),
  .write_through_reg(write_through_reg),
  .write_hit_invalidate_reg(write_hit_invalidate_reg),
  .write_combine_ok_reg(write_combine_ok_reg),
  .speculate_ok_reg(speculate_ok_reg),
  .read_memory_route_bit_reg(read_memory_route_bit_reg),
  .write_memory_route_bit_reg(write_memory_route_bit_reg),
  .type_invalid_reg(type_invalid_reg)
);
`default_nettype wire

/* File: tb_memory_range_type_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_memory_range_type_decoder;
  logic clk = 1'b0, rstn = 1'b0, range_enable, ext_type_enable;
  logic global_cache_disable, lookup_valid, lookup_is_fixed, pv, inv;
  logic [63:0] fixed_entry;
  logic [7:0] var_type_field;
  logic [2:0] fixed_field_sel, page_rank;
  logic [13:0] pol, held;
  logic [2:0] tbl [8] = '{3'h0, 3'h1, 3'h0, 3'h0, 3'h3, 3'h2, 3'h4, 3'h0};
  int n_mismatch = 0, compares = 0, cyc = 0;
  mrtd_decoder dut (
    .clk(clk), .rstn(rstn), .range_enable(range_enable),
    .ext_type_enable(ext_type_enable),
    .global_cache_disable(global_cache_disable),
    .lookup_valid(lookup_valid), .lookup_is_fixed(lookup_is_fixed),
    .fixed_entry(fixed_entry), .fixed_field_sel(fixed_field_sel),
    .var_type_field(var_type_field), .page_rank(page_rank),
    .policy_valid_reg(pv), .policy_rank_reg(pol[13:11]),
    .bypass_cache_reg(pol[10]), .read_alloc_reg(pol[9]),
    .write_alloc_reg(pol[8]), .write_through_reg(pol[7]),
    .write_hit_invalidate_reg(pol[6]), .write_combine_ok_reg(pol[5]),
    .speculate_ok_reg(pol[4]), .read_memory_route_bit_reg(pol[3]),
    .write_memory_route_bit_reg(pol[2]), .type_invalid_reg(pol[1]),
    .reserved_err_reg(pol[0]));
  mrtd_cache_model cm (.clk(clk), .rstn(rstn), .pv(pv), .pol(pol),
    .held_reg(held));
  initial begin
    forever #2 clk = ~clk;
  end
  task chk(input string nm, input logic [13:0] s, e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one lookup; field also sits in every other byte inverted, so a wrong
  // byte select shows; f=0 compares only route and error flags
  task t(input logic x, y, e, input logic [7:0] v,
         input logic [2:0] p, r, input logic [3:0] lo, input logic f);
    logic [13:0] w;
    {lookup_is_fixed, ext_type_enable, range_enable} = {x, y, e};
    fixed_field_sel = v[2:0];
    fixed_entry = {8{~v}};
    fixed_entry[v[2:0]*8 +: 8] = v;
    var_type_field = v;
    page_rank = p;
    lookup_valid = 1'b1;
    @(negedge clk);
    lookup_valid = 1'b0;
    chk("valid", {13'h0000, pv}, 14'h0001);
    @(negedge clk);
    w = {r, r < 2, r > 1, r == 4, r == 2 || r == 3,
         r == 2, r == 1, r != 0, lo};
    if (!f) w[13:4] = 10'h000;
    chk("policy", {held[13:4] & {10{f}}, held[3:0]}, w);
    $display("done %h", v);
  endtask
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  initial begin
    {range_enable, ext_type_enable, global_cache_disable} = 3'h0;
    {lookup_valid, lookup_is_fixed, fixed_field_sel} = 5'h00;
    {fixed_entry, var_type_field, page_rank} = 75'h0;
    @(negedge clk);
    // in reset the policy is idle and uncacheable
    chk("reset policy", pol, 14'h0400);
    chk("reset valid", {13'h0000, pv}, 14'h0000);
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    // reserved bits kept zero here; only types 2, 3 and 7 are undefined
    for (int i = 0; i < 8; i++) begin
      inv = (i == 2) || (i == 3) || (i == 7);
      t(1, 0, 1, 8'(i), 4, tbl[i], {2'h0, inv, 1'b0}, 1);
    end
    t(0, 0, 1, 8'h06, 2, 2, 4'h0, 1);
    t(1, 1, 1, 8'h1e, 4, 4, 4'hc, 1);
    t(1, 1, 1, 8'h26, 4, 4, 4'h1, 0);
    t(0, 1, 1, 8'h1e, 4, 4, 4'h1, 0);
    t(1, 0, 1, 8'h1e, 4, 4, 4'h1, 0);
    global_cache_disable = 1'b1;
    t(1, 0, 1, 8'h06, 4, 0, 4'h0, 1);
    global_cache_disable = 1'b0;
    t(1, 1, 0, 8'h06, 4, 0, 4'h0, 1);
    end_of_test;
  end
endmodule // tb_memory_range_type_decoder
`default_nettype wire
